// ---- irq_enable_and_error_flags.sv ----
// Purpose: request flags, enable masking, interrupt pin drive and the
//          contactless error flags, reached over APB
// Assumes: all event inputs are one-cycle pulses synchronous to pclk
// Notes:   one wait state on every APB access; prdata is registered
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
module irq_enable_and_error_flags #(
	parameter int addr_width = 12
) (
	input  wire logic                           pclk,
	input  wire logic                           presetn,
	input  wire logic                           psel,
	input  wire logic                           penable,
	input  wire logic                           pwrite,
	input  wire logic [addr_width-1:0]          paddr,
	input  wire logic [31:0]                    pwdata,
	output logic      [31:0]                    prdata,
	output logic                                pready,
	output logic                                pslverr,
	input  wire irq_flags_pkg::request_events_t req_events,
	input  wire irq_flags_pkg::frame_report_t   frame_report,
	input  wire logic                           emd_suppress,
	input  wire logic                           nvm_cmd_end,
	input  wire logic                           nvm_cmd_fail,
	input  wire logic                           queue_write,
	input  wire logic                           queue_full,
	input  wire logic                           queue_empty,
	input  wire logic                           queue_flush,
	input  wire logic                           crc_sending,
	input  wire logic                           auth_active,
	input  wire logic [2:0]                     comm_state,
	input  wire logic                           cl_cmd_start,
	input  wire logic                           receive_phase_start,
	input  wire logic                           multi_frame_receive,
	input  wire logic                           error_flags_stored,
	input  wire logic                           send_request,
	input  wire logic                           framing_rule_error,
	input  wire logic                           parity_crc_error,
	output logic                                queue_write_accept,
	output logic                                receive_decoder,
	output logic                                combined_request,
	output logic                                irq_out,
	output logic                                irq_oe
);

	// ----------------------------------------------------------------
	// register state
	// ----------------------------------------------------------------
	logic [7:0]  enable0_reg;
	logic [7:0]  enable1_reg;
	logic [7:0]  request0_reg;
	logic [7:0]  request0_next;
	logic [5:0]  request1_reg;
	logic [5:0]  request1_next;
	logic [7:0]  error_reg;
	logic [7:0]  error_next;
	logic [31:0] prdata_reg;
	logic        pready_reg;
	logic        pslverr_reg;
	logic        irq_out_reg;
	logic        irq_oe_reg;
	logic        decoder_reg;

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	wire logic [9:0] word_idx   = 10'(paddr[addr_width-1:2]);
	wire logic       aligned    = (paddr[1:0] == 2'h0);
	wire logic       access     = psel & penable;
	wire logic       commit     = access & pready_reg;
	wire logic       hit_req0   = aligned &
		(word_idx == irq_flags_pkg::request_flags0_idx);
	wire logic       hit_req1   = aligned &
		(word_idx == irq_flags_pkg::request_flags1_idx);
	wire logic       hit_en0    = aligned &
		(word_idx == irq_flags_pkg::enable_group0_idx);
	wire logic       hit_en1    = aligned &
		(word_idx == irq_flags_pkg::enable_group1_idx);
	wire logic       hit_err    = aligned &
		(word_idx == irq_flags_pkg::error_flags_idx);
	wire logic       mapped     = hit_req0 | hit_req1 | hit_en0 |
		hit_en1 | hit_err;
	wire logic       wr_commit  = commit & pwrite & mapped;
	wire logic       wr_req0    = wr_commit & hit_req0;
	wire logic       wr_req1    = wr_commit & hit_req1;
	// a read-only error register ignores writes but answers without error
	wire logic       set_mode   = pwdata[irq_flags_pkg::set_select_bit];

	// ----------------------------------------------------------------
	// error flag set and clear terms
	// ----------------------------------------------------------------
	wire logic rx_phase = (comm_state == irq_flags_pkg::state_rx_wait) |
		(comm_state == irq_flags_pkg::state_wait_data) |
		(comm_state == irq_flags_pkg::state_receiving);
	wire logic wr_violation_set = queue_write &
		(crc_sending | rx_phase | auth_active);
	// multi-frame receive moves the clear to after the flag store
	wire logic wr_violation_clr = multi_frame_receive ?
		error_flags_stored : cl_cmd_start;
	wire logic overflow_set  = queue_write & queue_full;
	wire logic short_bits    = frame_report.frame_end &
		(frame_report.bit_count < irq_flags_pkg::min_frame_bits);
	wire logic short_bytes   = frame_report.frame_end & emd_suppress &
		(frame_report.byte_count < irq_flags_pkg::min_emd_bytes);
	wire logic frame_drop    = short_bits | short_bytes;
	wire logic frame_keep    = frame_report.frame_end & ~frame_drop;
	wire logic empty_send_set = send_request & queue_empty;

	// queue writes are refused while overflow is flagged
	assign queue_write_accept = queue_write & ~queue_full &
		~error_reg[irq_flags_pkg::overflow_bit];

	// error register next value; a set in the clearing cycle wins
	always_comb begin
		error_next = error_reg;
		if (nvm_cmd_end) begin
			error_next[irq_flags_pkg::nvm_err_bit] = nvm_cmd_fail;
		end
		if (wr_violation_clr) begin
			error_next[irq_flags_pkg::wr_violation_bit] = 1'b0;
		end
		if (wr_violation_set) begin
			error_next[irq_flags_pkg::wr_violation_bit] = 1'b1;
		end
		if (queue_flush) begin
			error_next[irq_flags_pkg::overflow_bit] = 1'b0;
		end
		if (overflow_set) begin
			error_next[irq_flags_pkg::overflow_bit] = 1'b1;
		end
		if (receive_phase_start) begin
			error_next[irq_flags_pkg::short_frame_bit] = 1'b0;
		end
		if (short_bits) begin
			error_next[irq_flags_pkg::short_frame_bit] = 1'b1;
		end
		if (cl_cmd_start) begin
			error_next[irq_flags_pkg::empty_send_bit] = 1'b0;
		end
		if (empty_send_set) begin
			error_next[irq_flags_pkg::empty_send_bit] = 1'b1;
		end
	end

	// flags hold between their set and clear events
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			error_reg <= irq_flags_pkg::error_reset;
		end else begin
			error_reg <= error_next;
		end
	end

	// ----------------------------------------------------------------
	// request flags
	// ----------------------------------------------------------------
	wire logic fault_source = error_reg[irq_flags_pkg::wr_violation_bit] |
		error_reg[irq_flags_pkg::overflow_bit] | framing_rule_error |
		error_reg[irq_flags_pkg::empty_send_bit] |
		parity_crc_error;
	wire logic [7:0] hw_set0 = {1'b0, req_events.high_level_alert,
		req_events.low_level_alert, req_events.cmd_done,
		req_events.send_done, frame_keep, fault_source,
		req_events.frame_start};
	wire logic [5:0] hw_set1 = {req_events.card_sense,
		req_events.counter_underflow};

	// host set or clear by ones, hardware set applied last so it wins
	always_comb begin
		request0_next = request0_reg;
		request1_next = request1_reg;
		if (wr_req0) begin
			request0_next = set_mode ? (request0_reg | pwdata[7:0]) :
				(request0_reg & ~pwdata[7:0]);
		end
		if (wr_req1) begin
			request1_next = set_mode ? (request1_reg | pwdata[5:0]) :
				(request1_reg & ~pwdata[5:0]);
		end
		request0_next = request0_next | hw_set0;
		request0_next[irq_flags_pkg::set_select_bit] = 1'b0;
		request1_next = request1_next | hw_set1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			request0_reg <= irq_flags_pkg::request_reset;
			request1_reg <= 6'h00;
		end else begin
			request0_reg <= request0_next;
			request1_reg <= request1_next;
		end
	end

	// ----------------------------------------------------------------
	// enable masking and combined request
	// ----------------------------------------------------------------
	// one and gate per source keeps each mask bit independent
	wire logic [6:0] masked0 = request0_reg[6:0] &
		enable0_reg[6:0];
	wire logic [5:0] masked1 = request1_reg &
		enable1_reg[5:0];
	// bits 1 and 0 of masked0 carry fault and frame start
	// bit 2 of masked0 carries receive done
	assign combined_request = (|masked0) | (|masked1);

	// ----------------------------------------------------------------
	// interrupt pin
	// ----------------------------------------------------------------
	wire logic routed = enable1_reg[irq_flags_pkg::pin_routing_bit] &
		combined_request;
	// unrouted request gives the inactive level after inversion
	wire logic pin_level = routed ^
		enable0_reg[irq_flags_pkg::pin_polarity_bit];
	wire logic push_pull = enable1_reg[irq_flags_pkg::pin_drive_bit];
	// open drain only pulls low, and floats while unrouted
	wire logic oe_next = push_pull ? 1'b1 :
		(enable1_reg[irq_flags_pkg::pin_routing_bit] &
		~pin_level);
	wire logic out_next = push_pull ? pin_level : 1'b0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_out_reg <= 1'b0;
			irq_oe_reg  <= 1'b0;
		end else begin
			irq_out_reg <= out_next;
			irq_oe_reg  <= oe_next;
		end
	end

	// ----------------------------------------------------------------
	// receive decoder enable
	// ----------------------------------------------------------------
	// a dropped frame leaves the decoder armed for the next one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			decoder_reg <= 1'b0;
		end else if (receive_phase_start) begin
			decoder_reg <= 1'b1;
		end else if (frame_keep) begin
			decoder_reg <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// apb registers and read path
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enable0_reg <= irq_flags_pkg::enable0_reset;
			enable1_reg <= irq_flags_pkg::enable1_reset;
		end else begin
			if (wr_commit & hit_en0) begin
				enable0_reg <= pwdata[7:0];
			end
			if (wr_commit & hit_en1) begin
				enable1_reg <= pwdata[7:0];
			end
		end
	end

	wire logic [7:0] read_byte =
		hit_req0 ? request0_reg :
		hit_req1 ? {1'b0, combined_request, request1_reg} :
		hit_en0  ? enable0_reg :
		hit_en1  ? enable1_reg :
		hit_err  ? error_reg : 8'h00;

	// one wait state so read data comes from a flip-flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= 32'h00000000;
		end else begin
			pready_reg  <= access & ~pready_reg;
			pslverr_reg <= access & ~pready_reg & ~mapped;
			if (access & ~pready_reg & ~pwrite) begin
				prdata_reg <= {24'h000000, read_byte};
			end
		end
	end

	assign prdata          = prdata_reg;
	assign pready          = pready_reg;
	assign pslverr         = pslverr_reg;
	assign irq_out         = irq_out_reg;
	assign irq_oe          = irq_oe_reg;
	assign receive_decoder = decoder_reg;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	pin_polarity_a: assert property (push_pull |=>
		irq_out == ($past(routed) ^ $past(enable0_reg[7])))
		else $error("pin polarity wrong");
	mask_gate_a: assert property (
		(enable0_reg == 8'h00) && (enable1_reg[5:0] == 6'h00)
		|-> !combined_request)
		else $error("masked request reached combined");
	alert_pass_a: assert property (request0_reg[6] && enable0_reg[6]
		|-> combined_request)
		else $error("enabled alert not combined");
	drain_float_a: assert property (!push_pull && !enable1_reg[6]
		|=> !irq_oe)
		else $error("open drain drives while unrouted");
	od_no_high_a: assert property (!$past(push_pull) |-> !irq_out)
		else $error("open drain drove high");
	overflow_drop_a: assert property (error_reg[5] |->
		!queue_write_accept)
		else $error("write accepted after overflow");
	overflow_set_a: assert property (queue_write && queue_full
		|=> error_reg[5])
		else $error("overflow not flagged");
	short_frame_a: assert property (short_bits |=> error_reg[4] &&
		!($past(request0_reg[2]) ^ request0_reg[2] && !$past(wr_req0)))
		else $error("short frame raised receive request");
	fault_req_a: assert property (fault_source |=> request0_reg[1])
		else $error("fault request not set");
	violation_a: assert property (wr_violation_set |=> error_reg[6]
		##1 error_reg[6] || $past(wr_violation_clr))
		else $error("write violation lost");
	nvm_outcome_a: assert property (nvm_cmd_end |=>
		error_reg[7] == $past(nvm_cmd_fail))
		else $error("memory command outcome not kept");
	apb_wait_a: assert property ($rose(access) |=> pready ##1 !pready)
		else $error("apb answer timing wrong");

	read_cov_c: cover property (commit && !pwrite && hit_err);
	pin_cov_c: cover property (routed && push_pull ##1 irq_out);
	drop_cov_c: cover property (frame_drop ##1 error_reg[4]);
	ovf_cov_c: cover property (error_reg[5] && queue_write);

endmodule

// ---- irq_flags_pkg.sv ----
// Purpose: shared constants and carriers for the request enable and
//          contactless error flag block
// Assumes: registers are 8 bits wide, one per aligned 32-bit APB word
// Notes:   register indices are word numbers; byte address is index * 4
package irq_flags_pkg;

	// ----------------------------------------------------------------
	// register indices and bus constants
	// ----------------------------------------------------------------
	localparam logic [9:0] request_flags0_idx = 10'h006;
	localparam logic [9:0] request_flags1_idx = 10'h007;
	localparam logic [9:0] enable_group0_idx  = 10'h008;
	localparam logic [9:0] enable_group1_idx  = 10'h009;
	localparam logic [9:0] error_flags_idx    = 10'h00A;
	localparam logic [7:0] enable0_reset      = 8'h00;
	localparam logic [7:0] enable1_reset      = 8'h00;
	localparam logic [7:0] request_reset      = 8'h00;
	localparam logic [7:0] error_reset        = 8'h00;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int set_select_bit         = 7;
	localparam int pin_polarity_bit       = 7;
	localparam int pin_drive_bit          = 7;
	localparam int pin_routing_bit        = 6;
	localparam int combined_bit           = 6;
	localparam int card_sense_bit         = 5;
	localparam int nvm_err_bit            = 7;
	localparam int wr_violation_bit       = 6;
	localparam int overflow_bit           = 5;
	localparam int short_frame_bit        = 4;
	localparam int empty_send_bit         = 3;
	localparam int fault_request_bit      = 1;
	localparam int timer_count            = 5;

	// ----------------------------------------------------------------
	// frame length limits and transceiver state codes
	// ----------------------------------------------------------------
	localparam logic [3:0] min_frame_bits  = 4'h4;
	localparam logic [3:0] min_emd_bytes   = 4'h3;
	localparam logic [2:0] state_rx_wait   = 3'h5;
	localparam logic [2:0] state_wait_data = 3'h6;
	localparam logic [2:0] state_receiving = 3'h7;

	// hardware request sources, one pulse per event
	typedef struct packed {
		logic       high_level_alert;
		logic       low_level_alert;
		logic       cmd_done;
		logic       send_done;
		logic       frame_start;
		logic       card_sense;
		logic [4:0] counter_underflow;
	} request_events_t;

	// receive frame end report
	typedef struct packed {
		logic       frame_end;
		logic [3:0] bit_count;
		logic [3:0] byte_count;
	} frame_report_t;

endpackage

// ---- irq_host_model.sv ----
// Purpose: host side of the interrupt pin, resolving the wire level
// Assumes: the board holds the line high through a pull-up resistor
// Notes:   push-pull and open-drain drive both resolve here
`timescale 1ns/1ps
module irq_host_model (
	input  wire logic irq_out,
	input  wire logic irq_oe,
	output logic      irq_pin
);
	// -----------------------------------------------------------
	// wire resolution
	// -----------------------------------------------------------
	// released line never keeps the last value; pull-up wins
	assign irq_pin = irq_oe ? irq_out : 1'b1;
endmodule

// ---- irq_enable_and_error_flags_tb.sv ----
// Purpose: register level checks of request masking, pin drive and
//          the contactless error flags
// Assumes: one wait state apb slave, event inputs are single pulses
// Notes:   framing and integrity error inputs are pulsed once each
`timescale 1ns/1ps
module irq_enable_and_error_flags_tb;
	// -----------------------------------------------------------
	// signals, clock and design
	// -----------------------------------------------------------
	localparam logic [11:0] a_req0 =
		{irq_flags_pkg::request_flags0_idx, 2'b00};
	localparam logic [11:0] a_req1 =
		{irq_flags_pkg::request_flags1_idx, 2'b00};
	localparam logic [11:0] a_en0  =
		{irq_flags_pkg::enable_group0_idx, 2'b00};
	localparam logic [11:0] a_en1  =
		{irq_flags_pkg::enable_group1_idx, 2'b00};
	localparam logic [11:0] a_err  =
		{irq_flags_pkg::error_flags_idx, 2'b00};
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic        pwrite = 1'b0, emd_suppress = 1'b0, nvm_cmd_fail = 1'b0;
	logic        queue_full = 1'b0, queue_empty = 1'b0, crc_sending = 1'b0;
	logic        auth_active = 1'b0, multi_frame_receive = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000, prdata;
	logic        pready, pslverr, queue_write_accept, receive_decoder;
	logic        combined_request, irq_out, irq_oe, irq_pin;
	logic [2:0]  comm_state = 3'h0;
	logic [3:0]  fbits = 4'h0, fbytes = 4'h0;
	logic [10:0] pl = 11'h000;
	int          err_count = 0, checks = 0;
	irq_flags_pkg::request_events_t req_events;
	irq_flags_pkg::frame_report_t   frame_report;

	// pulses live in one vector so a single task can fire any of them
	assign req_events = {11{pl[8]}};
	assign frame_report = {pl[7], fbits, fbytes};
	always #20 pclk = ~pclk;

	irq_enable_and_error_flags dut (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .req_events, .frame_report,
		.emd_suppress, .nvm_cmd_end(pl[0]), .nvm_cmd_fail,
		.queue_write(pl[1]), .queue_full, .queue_empty,
		.queue_flush(pl[2]), .crc_sending, .auth_active, .comm_state,
		.cl_cmd_start(pl[3]), .receive_phase_start(pl[4]),
		.multi_frame_receive, .error_flags_stored(pl[5]),
		.send_request(pl[6]), .framing_rule_error(pl[9]),
		.parity_crc_error(pl[10]), .queue_write_accept, .receive_decoder,
		.combined_request, .irq_out, .irq_oe
	);
	irq_host_model host (.irq_out, .irq_oe, .irq_pin);

	// -----------------------------------------------------------
	// tasks
	// -----------------------------------------------------------
	task automatic final_report;
		if (err_count == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// request held until pready is seen high at a rising edge
	task automatic apb(input logic wr, input logic [11:0] a,
			input logic [31:0] d, output logic [31:0] q, output logic e);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16) begin
			err_count++;
			final_report;
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] x,
			input logic xe);
		logic [31:0] q;
		logic        e;
		apb(1'b0, a, 32'h00000000, q, e);
		chk(q, x);
		chk({31'h0, e}, {31'h0, xe});
	endtask

	task automatic cmb(input logic x);
		@(negedge pclk);
		chk({31'h0, combined_request}, {31'h0, x});
	endtask

	task automatic pulse(input int i);
		@(posedge pclk);
		pl[i] <= 1'b1;
		@(posedge pclk);
		pl[i] <= 1'b0;
	endtask

	// queue write whose acceptance is looked at mid-pulse
	task automatic qw(input logic x);
		@(posedge pclk);
		pl[1] <= 1'b1;
		@(negedge pclk);
		chk({31'h0, queue_write_accept}, {31'h0, x});
		@(posedge pclk);
		pl[1] <= 1'b0;
	endtask

	// -----------------------------------------------------------
	// main sequence
	// -----------------------------------------------------------
	initial begin
		logic [11:0] fa, ea;
		logic [31:0] m;
		logic        act, po, pe;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rd(a_req0, 32'h00, 1'b0);
		rd(a_req1, 32'h00, 1'b0);
		rd(a_en0, 32'h00, 1'b0);
		rd(a_en1, 32'h00, 1'b0);
		rd(a_err, 32'h00, 1'b0);
		rd(12'h0FC, 32'h00, 1'b1);
		rd(12'h021, 32'h00, 1'b1);
		wr(a_en0, 32'hA5);
		rd(a_en0, 32'hA5, 1'b0);
		wr(a_en0, 32'h00);
		// every source: set, unmask, clear, each seen on combined
		for (int i = 0; i < 13; i++) begin
			fa = (i < 7) ? a_req0 : a_req1;
			ea = (i < 7) ? a_en0 : a_en1;
			m = (i < 7) ? (32'h1 << i) : (32'h1 << (i - 7));
			wr(fa, m | 32'h80);
			rd(fa, m, 1'b0);
			cmb(1'b0);
			wr(ea, m);
			if (i < 4)
				cmb(1'b1);
			else if (i < 7)
				cmb(1'b1);
			else
				cmb(1'b1);
			wr(fa, m);
			cmb(1'b0);
			wr(ea, 32'h00);
		end
		// pin: all polarity, routing and drive combinations
		wr(a_req0, 32'h81);
		for (int c = 0; c < 16; c++) begin
			wr(a_en0, {24'h0, c[1], 6'h00, c[0]});
			wr(a_en1, {24'h0, c[3], c[2], 6'h00});
			@(posedge pclk);
			@(negedge pclk);
			act = (c[2] & c[0]) ^ c[1];
			po = c[3] ? 1'b1 : (c[2] & !act);
			chk({31'h0, irq_oe}, {31'h0, po});
			pe = c[3] ? act : !po;
			chk({31'h0, irq_pin}, {31'h0, pe});
		end
		wr(a_req0, 32'h01);
		wr(a_en0, 32'h00);
		wr(a_en1, 32'h00);
		// memory command outcome, error register is read only
		nvm_cmd_fail <= 1'b1;
		pulse(0);
		rd(a_err, 32'h80, 1'b0);
		nvm_cmd_fail <= 1'b0;
		pulse(0);
		wr(a_err, 32'hFF);
		rd(a_err, 32'h00, 1'b0);
		// each forbidden phase for a queue write
		for (int k = 0; k < 5; k++) begin
			comm_state <= (k < 3) ? 3'(5 + k) : 3'h0;
			crc_sending <= (k == 3);
			auth_active <= (k == 4);
			pulse(1);
			comm_state <= 3'h0;
			crc_sending <= 1'b0;
			auth_active <= 1'b0;
			rd(a_err, 32'h40, 1'b0);
			if (k == 0)
				rd(a_req0, 32'h02, 1'b0);
			pulse(3);
			rd(a_err, 32'h00, 1'b0);
		end
		multi_frame_receive <= 1'b1;
		comm_state <= 3'h6;
		pulse(1);
		comm_state <= 3'h0;
		pulse(3);
		rd(a_err, 32'h40, 1'b0);
		pulse(5);
		rd(a_err, 32'h00, 1'b0);
		multi_frame_receive <= 1'b0;
		// overflow, then writes refused until the flag goes
		queue_full <= 1'b1;
		qw(1'b0);
		queue_full <= 1'b0;
		qw(1'b0);
		rd(a_err, 32'h20, 1'b0);
		pulse(2);
		qw(1'b1);
		wr(a_req0, 32'h7F);
		// short frames dropped, decoder left running
		pulse(4);
		fbits <= 4'h3;
		pulse(7);
		rd(a_err, 32'h10, 1'b0);
		rd(a_req0, 32'h00, 1'b0);
		chk({31'h0, receive_decoder}, 32'h1);
		pulse(4);
		rd(a_err, 32'h00, 1'b0);
		emd_suppress <= 1'b1;
		fbits <= 4'hF;
		fbytes <= 4'h2;
		pulse(7);
		rd(a_req0, 32'h00, 1'b0);
		fbytes <= 4'h3;
		pulse(7);
		rd(a_req0, 32'h04, 1'b0);
		chk({31'h0, receive_decoder}, 32'h0);
		pulse(4);
		// sending with nothing queued
		queue_empty <= 1'b1;
		pulse(6);
		rd(a_err, 32'h08, 1'b0);
		rd(a_req0, 32'h06, 1'b0);
		// external framing and integrity errors feed the fault request
		queue_empty <= 1'b0;
		pulse(3);
		wr(a_req0, 32'h7F);
		rd(a_req0, 32'h00, 1'b0);
		pulse(9);
		rd(a_req0, 32'h02, 1'b0);
		wr(a_req0, 32'h7F);
		pulse(10);
		rd(a_req0, 32'h02, 1'b0);
		// every request event at once, only the high alert enabled
		wr(a_en0, 32'h40);
		pulse(8);
		cmb(1'b1);
		rd(a_req0, 32'h7B, 1'b0);
		rd(a_req1, 32'h7F, 1'b0);
		final_report;
	end
endmodule
